// ### hdl/sics_pkg.sv
// Constants, register map and carrier types of the step interpolator.
// Assumes one 125 MHz clock and a plain register port with 32-bit data.
package sics_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] SICS_OFS_DRV_CTRL = 8'h00;
  localparam logic [7:0] SICS_OFS_DRV_CONF = 8'h04;
  localparam logic [7:0] SICS_OFS_LOAD_CUR = 8'h08;
  localparam logic [7:0] SICS_OFS_DIRECT   = 8'h0c;
  localparam logic [7:0] SICS_OFS_STATUS   = 8'h10;
  localparam logic [7:0] SICS_OFS_PERIOD   = 8'h14;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SICS_RESOLUTION_SELECT_LSB   = 0;
  localparam int SICS_DOUBLE_EDGE_SELECT_BIT  = 8;
  localparam int SICS_INTERPOLATE_ENABLE_BIT = 9;
  localparam int SICS_SENSE_RANGE_SELECT_BIT = 0;
  localparam int SICS_DIRECT_BIT = 1;
  localparam int SICS_CS_LSB     = 0;
  localparam int SICS_COILA_LSB  = 0;
  localparam int SICS_COILB_LSB  = 16;
  localparam int SICS_STANDSTILL_FLAG_BIT   = 16;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] SICS_RESOLUTION_SELECT_RST   = 4'h4;
  localparam logic       SICS_DOUBLE_EDGE_SELECT_RST  = 1'h0;
  localparam logic       SICS_INTERPOLATE_ENABLE_RST = 1'h0;
  localparam logic       SICS_SENSE_RANGE_SELECT_RST = 1'h0;
  localparam logic       SICS_DIRECT_RST = 1'h0;
  localparam logic [4:0] SICS_CS_RST     = 5'h1f;

  // ************************************************************
  // Counts and scaling
  // ************************************************************
  localparam logic [19:0] SICS_INTERVAL_MAX = 20'hfffff;
  localparam logic [3:0]  SICS_RESOLUTION_SELECT_MAX     = 4'h8;
  localparam logic [4:0]  SICS_SUBSTEPS     = 5'h10;
  localparam int          SICS_SUB_SHIFT    = 4;
  localparam logic [8:0]  SICS_VFS_HIGH_MV  = 9'h145;
  localparam logic [8:0]  SICS_VFS_LOW_MV   = 9'h0ad;
  // Table amplitude 248 times scale divisor 32
  localparam logic signed [24:0] SICS_FULL_DIV = 25'sh0001f00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sics_bus_req_t;

  typedef struct packed {
    logic signed [8:0] a;
    logic signed [8:0] b;
  } sics_coil_t;

  typedef struct packed {
    logic signed [9:0] a;
    logic signed [9:0] b;
  } sics_target_t;

  typedef enum logic {SICS_PH_IDLE, SICS_PH_RUN} sics_phase_t;

  // Quarter sine wave, entries 0 to 255
  localparam logic [7:0] SICS_SINE_TAB [256] = '{
    8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0a, 8'h0b,
    8'h0d, 8'h0e, 8'h10, 8'h11, 8'h13, 8'h15, 8'h16, 8'h18,
    8'h19, 8'h1b, 8'h1c, 8'h1e, 8'h1f, 8'h21, 8'h22, 8'h24,
    8'h25, 8'h27, 8'h28, 8'h2a, 8'h2b, 8'h2d, 8'h2e, 8'h30,
    8'h31, 8'h33, 8'h34, 8'h36, 8'h37, 8'h39, 8'h3a, 8'h3c,
    8'h3d, 8'h3e, 8'h40, 8'h41, 8'h43, 8'h44, 8'h46, 8'h47,
    8'h49, 8'h4a, 8'h4c, 8'h4d, 8'h4f, 8'h50, 8'h51, 8'h53,
    8'h54, 8'h56, 8'h57, 8'h59, 8'h5a, 8'h5b, 8'h5d, 8'h5e,
    8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h67, 8'h68, 8'h69,
    8'h6b, 8'h6c, 8'h6d, 8'h6f, 8'h70, 8'h72, 8'h73, 8'h74,
    8'h76, 8'h77, 8'h78, 8'h7a, 8'h7b, 8'h7c, 8'h7e, 8'h7f,
    8'h80, 8'h81, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88, 8'h89,
    8'h8a, 8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'h91, 8'h92, 8'h93,
    8'h94, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9a, 8'h9c, 8'h9d,
    8'h9e, 8'h9f, 8'ha0, 8'ha1, 8'ha3, 8'ha4, 8'ha5, 8'ha6,
    8'ha7, 8'ha8, 8'ha9, 8'haa, 8'hac, 8'had, 8'hae, 8'haf,
    8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7,
    8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf,
    8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7,
    8'hc8, 8'hc9, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce,
    8'hcf, 8'hcf, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd4,
    8'hd5, 8'hd6, 8'hd7, 8'hd7, 8'hd8, 8'hd9, 8'hda, 8'hda,
    8'hdb, 8'hdc, 8'hdc, 8'hdd, 8'hde, 8'hdf, 8'hdf, 8'he0,
    8'he1, 8'he1, 8'he2, 8'he2, 8'he3, 8'he4, 8'he4, 8'he5,
    8'he5, 8'he6, 8'he7, 8'he7, 8'he8, 8'he8, 8'he9, 8'he9,
    8'hea, 8'hea, 8'heb, 8'heb, 8'hec, 8'hec, 8'hed, 8'hed,
    8'hee, 8'hee, 8'hee, 8'hef, 8'hef, 8'hf0, 8'hf0, 8'hf0,
    8'hf1, 8'hf1, 8'hf1, 8'hf2, 8'hf2, 8'hf2, 8'hf3, 8'hf3,
    8'hf3, 8'hf4, 8'hf4, 8'hf4, 8'hf4, 8'hf5, 8'hf5, 8'hf5,
    8'hf5, 8'hf6, 8'hf6, 8'hf6, 8'hf6, 8'hf6, 8'hf7, 8'hf7,
    8'hf7, 8'hf7, 8'hf7, 8'hf7, 8'hf7, 8'hf7, 8'hf8, 8'hf8,
    8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8
  };

endpackage : sics_pkg

// ### hdl/sics_sine_lut.sv
// Sine and cosine coil values from the 10-bit microstep angle.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module sics_sine_lut (
  // Angle
  input  wire logic [9:0]         angle,
  // Coil values
  output sics_pkg::sics_coil_t    coil
);
  import sics_pkg::*;

  // ************************************************************
  // Quarter-wave unfolding
  // ************************************************************
  function automatic logic signed [8:0] sics_sine(input logic [9:0] ang);
    logic [7:0] idx;
    logic [8:0] mag;
    idx = ang[8] ? ~ang[7:0] : ang[7:0];
    mag = {1'b0, SICS_SINE_TAB[idx]};
    return ang[9] ? 9'(-$signed(mag)) : $signed(mag);
  endfunction : sics_sine

  // Coil A follows sine, coil B cosine
  always_comb
  begin
    coil.a = sics_sine(angle);
    coil.b = sics_sine(10'(angle + 10'h100));
  end

endmodule : sics_sine_lut

// ### hdl/sics_current_scale.sv
// Scales coil values by the current scale and the sense threshold.
// Inputs come from registers on the same clock; outputs are registered.
`timescale 1ns/1ps
module sics_current_scale (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Settings
  input  wire logic [4:0]         currentScale,
  input  wire logic               reduceActive,
  input  wire logic               senseRange,
  // Coil values
  input  sics_pkg::sics_coil_t    coilIn,
  // Targets in millivolts
  output sics_pkg::sics_target_t  coilTarget,
  output logic [8:0]              thresholdMv
);
  import sics_pkg::*;

  sics_target_t target_reg;
  sics_target_t target_next;
  logic [8:0]   thresh_reg;
  logic [8:0]   thresh_next;
  logic [5:0]   factor;

  // ************************************************************
  // Coil value to sense voltage target
  // ************************************************************
  function automatic logic signed [9:0] sics_to_mv(
    input logic signed [8:0] val,
    input logic [5:0]        fac,
    input logic [8:0]        vfs);
    logic signed [24:0] prod;
    prod = val * $signed({1'b0, fac}) * $signed({1'b0, vfs});
    return 10'(prod / SICS_FULL_DIV);
  endfunction : sics_to_mv

  always_comb
  begin
    factor = 6'({1'b0, currentScale} + 6'h01);
    if (reduceActive)
    begin
      factor = factor >> 1;
      if (factor == 6'h00)
      begin
        factor = 6'h01;
      end
    end
    thresh_next = senseRange ? SICS_VFS_LOW_MV
                             : SICS_VFS_HIGH_MV;
    target_next.a = sics_to_mv(coilIn.a, factor, thresh_next);
    target_next.b = sics_to_mv(coilIn.b, factor, thresh_next);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      target_reg <= '0;
      thresh_reg <= SICS_VFS_HIGH_MV;
    end
    else
    begin
      target_reg <= target_next;
      thresh_reg <= thresh_next;
    end
  end

  assign coilTarget  = target_reg;
  assign thresholdMv = thresh_reg;

endmodule : sics_current_scale

// ### hdl/sics_step_interpolator.sv
// Step/direction microstep counter with step interpolation, standstill
// detection, register port and coil current scaling.
// Assumes asynchronous pins and a single-cycle register port master.
`timescale 1ns/1ps
module sics_step_interpolator #(
  parameter logic [19:0] INTERVAL_LIMIT = sics_pkg::SICS_INTERVAL_MAX
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Register port
  input  sics_pkg::sics_bus_req_t busReq,
  output logic [31:0]             busRdata,
  // Pins
  input  wire logic               stepPin,
  input  wire logic               dirPin,
  input  wire logic               standaloneReducePin,
  // Motion status
  output logic [9:0]              microstepAngle,
  output logic                    standstillFlag,
  // Current control
  output sics_pkg::sics_target_t  coilTarget,
  output logic [8:0]              senseThresholdMv,
  output logic                    senseRangeSelect
);
  import sics_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic [2:0] syncC_reg;
  logic [2:0] pinLvl_reg;
  logic [2:0] pinLvl_next;
  logic       stepEdge;
  logic       stepRise;

  always_comb
  begin
    pinLvl_next = pinLvl_reg;
    for (int i = 0; i < 3; i++)
    begin
      if (syncB_reg[i] == syncC_reg[i])
      begin
        pinLvl_next[i] = syncC_reg[i];
      end
    end
    stepEdge = pinLvl_next[0] != pinLvl_reg[0];
    stepRise = stepEdge && pinLvl_next[0];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      syncA_reg  <= 3'h0;
      syncB_reg  <= 3'h0;
      syncC_reg  <= 3'h0;
      pinLvl_reg <= 3'h0;
    end
    else
    begin
      syncA_reg  <= {standaloneReducePin, dirPin, stepPin};
      syncB_reg  <= syncA_reg;
      syncC_reg  <= syncB_reg;
      pinLvl_reg <= pinLvl_next;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [3:0]  resolution_select_reg;
  logic [3:0]  resolution_select_next;
  logic        double_edge_select_reg;
  logic        double_edge_select_next;
  logic        interpolate_enable_reg;
  logic        interpolate_enable_next;
  logic        sense_range_select_reg;
  logic        sense_range_select_next;
  logic        direct_reg;
  logic        direct_next;
  logic [4:0]  cs_reg;
  logic [4:0]  cs_next;
  sics_coil_t  dcoil_reg;
  sics_coil_t  dcoil_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [9:0]  angle_reg;
  logic        standstill_flag_reg;
  logic [19:0] period_reg;

  always_comb
  begin
    resolution_select_next   = resolution_select_reg;
    double_edge_select_next  = double_edge_select_reg;
    interpolate_enable_next = interpolate_enable_reg;
    sense_range_select_next = sense_range_select_reg;
    direct_next = direct_reg;
    cs_next     = cs_reg;
    dcoil_next  = dcoil_reg;
    rdata_next  = 32'h0;
    if (busReq.wr)
    begin
      case (busReq.addr)
        SICS_OFS_DRV_CTRL:
        begin
          resolution_select_next   = busReq.wdata[SICS_RESOLUTION_SELECT_LSB +: 4];
          double_edge_select_next  = busReq.wdata[SICS_DOUBLE_EDGE_SELECT_BIT];
          interpolate_enable_next = busReq.wdata[SICS_INTERPOLATE_ENABLE_BIT];
        end
        SICS_OFS_DRV_CONF:
        begin
          sense_range_select_next = busReq.wdata[SICS_SENSE_RANGE_SELECT_BIT];
          direct_next = busReq.wdata[SICS_DIRECT_BIT];
        end
        SICS_OFS_LOAD_CUR:
        begin
          cs_next = busReq.wdata[SICS_CS_LSB +: 5];
        end
        SICS_OFS_DIRECT:
        begin
          dcoil_next.a = busReq.wdata[SICS_COILA_LSB +: 9];
          dcoil_next.b = busReq.wdata[SICS_COILB_LSB +: 9];
        end
        default:
        begin
        end
      endcase
    end
    if (busReq.rd)
    begin
      case (busReq.addr)
        SICS_OFS_DRV_CTRL:
        begin
          rdata_next[SICS_RESOLUTION_SELECT_LSB +: 4] = resolution_select_reg;
          rdata_next[SICS_DOUBLE_EDGE_SELECT_BIT]     = double_edge_select_reg;
          rdata_next[SICS_INTERPOLATE_ENABLE_BIT]    = interpolate_enable_reg;
        end
        SICS_OFS_DRV_CONF:
        begin
          rdata_next[SICS_SENSE_RANGE_SELECT_BIT] = sense_range_select_reg;
          rdata_next[SICS_DIRECT_BIT] = direct_reg;
        end
        SICS_OFS_LOAD_CUR:
        begin
          rdata_next[SICS_CS_LSB +: 5] = cs_reg;
        end
        SICS_OFS_DIRECT:
        begin
          rdata_next[SICS_COILA_LSB +: 9] = dcoil_reg.a;
          rdata_next[SICS_COILB_LSB +: 9] = dcoil_reg.b;
        end
        SICS_OFS_STATUS:
        begin
          rdata_next[9:0]           = angle_reg;
          rdata_next[SICS_STANDSTILL_FLAG_BIT] = standstill_flag_reg;
        end
        SICS_OFS_PERIOD:
        begin
          rdata_next[19:0] = period_reg;
        end
        default:
        begin
          rdata_next = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      resolution_select_reg   <= SICS_RESOLUTION_SELECT_RST;
      double_edge_select_reg  <= SICS_DOUBLE_EDGE_SELECT_RST;
      interpolate_enable_reg <= SICS_INTERPOLATE_ENABLE_RST;
      sense_range_select_reg <= SICS_SENSE_RANGE_SELECT_RST;
      direct_reg <= SICS_DIRECT_RST;
      cs_reg     <= SICS_CS_RST;
      dcoil_reg  <= '0;
      rdata_reg  <= 32'h0;
    end
    else
    begin
      resolution_select_reg   <= resolution_select_next;
      double_edge_select_reg  <= double_edge_select_next;
      interpolate_enable_reg <= interpolate_enable_next;
      sense_range_select_reg <= sense_range_select_next;
      direct_reg <= direct_next;
      cs_reg     <= cs_next;
      dcoil_reg  <= dcoil_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ************************************************************
  // Microstep counter and interpolator
  // ************************************************************
  sics_phase_t phase_reg;
  sics_phase_t phase_next;
  logic [9:0]  angle_next;
  logic [9:0]  target_reg;
  logic [9:0]  target_next;
  logic        dirLat_reg;
  logic        dirLat_next;
  logic        standstill_flag_next;
  logic [19:0] interval_reg;
  logic [19:0] interval_next;
  logic [19:0] period_next;
  logic [15:0] subPer_reg;
  logic [15:0] subPer_next;
  logic [15:0] subCnt_reg;
  logic [15:0] subCnt_next;
  logic [4:0]  left_reg;
  logic [4:0]  left_next;
  logic        activeEdge;
  logic [9:0]  stepSize;
  logic [3:0]  mresEff;

  // Move by a signed amount set by the direction
  function automatic logic [9:0] sics_move(
    input logic [9:0] pos,
    input logic [9:0] amount,
    input logic       down);
    return down ? 10'(pos - amount) : 10'(pos + amount);
  endfunction : sics_move

  always_comb
  begin
    activeEdge = stepRise || (stepEdge && double_edge_select_reg);
    mresEff    = (resolution_select_reg > SICS_RESOLUTION_SELECT_MAX) ? SICS_RESOLUTION_SELECT_MAX : resolution_select_reg;
    stepSize   = 10'h001 << mresEff;
    phase_next    = phase_reg;
    angle_next    = angle_reg;
    target_next   = target_reg;
    dirLat_next   = dirLat_reg;
    standstill_flag_next     = standstill_flag_reg;
    period_next   = period_reg;
    subPer_next   = subPer_reg;
    subCnt_next   = subCnt_reg;
    left_next     = left_reg;
    // Saturating interval count
    if (activeEdge)
    begin
      interval_next = 20'h1;
      period_next   = interval_reg;
      subPer_next   = interval_reg[SICS_SUB_SHIFT +: 16];
      standstill_flag_next     = 1'b0;
    end
    else if (interval_reg >= INTERVAL_LIMIT)
    begin
      interval_next = interval_reg;
      standstill_flag_next     = 1'b1;
    end
    else
    begin
      interval_next = 20'(interval_reg + 20'h1);
    end
    case (phase_reg)
      SICS_PH_IDLE,
      SICS_PH_RUN:
      begin
        if (activeEdge && interpolate_enable_reg)
        begin
          // Finish the old step at once, then start sixteen new ones
          dirLat_next = pinLvl_next[1];
          angle_next  = sics_move(target_reg, 10'h001,
                                  pinLvl_next[1]);
          target_next = sics_move(target_reg, 10'({5'h0, SICS_SUBSTEPS}),
                                  pinLvl_next[1]);
          left_next   = 5'(SICS_SUBSTEPS - 5'h01);
          subCnt_next = 16'h0;
          phase_next  = SICS_PH_RUN;
        end
        else if (activeEdge)
        begin
          angle_next  = sics_move(angle_reg, stepSize,
                                  pinLvl_next[1]);
          target_next = angle_next;
          left_next   = 5'h0;
          phase_next  = SICS_PH_IDLE;
        end
        else if (phase_reg == SICS_PH_RUN)
        begin
          if (16'(subCnt_reg + 16'h1) >= subPer_reg)
          begin
            angle_next  = sics_move(angle_reg, 10'h001, dirLat_reg);
            subCnt_next = 16'h0;
            left_next   = 5'(left_reg - 5'h01);
            if (left_reg == 5'h01)
            begin
              phase_next = SICS_PH_IDLE;
            end
          end
          else
          begin
            subCnt_next = 16'(subCnt_reg + 16'h1);
          end
        end
      end
      default:
      begin
        phase_next = SICS_PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_reg    <= SICS_PH_IDLE;
      angle_reg    <= 10'h0;
      target_reg   <= 10'h0;
      dirLat_reg   <= 1'b0;
      standstill_flag_reg     <= 1'b0;
      interval_reg <= 20'h0;
      period_reg   <= 20'h0;
      subPer_reg   <= 16'h0;
      subCnt_reg   <= 16'h0;
      left_reg     <= 5'h0;
    end
    else
    begin
      phase_reg    <= phase_next;
      angle_reg    <= angle_next;
      target_reg   <= target_next;
      dirLat_reg   <= dirLat_next;
      standstill_flag_reg     <= standstill_flag_next;
      interval_reg <= interval_next;
      period_reg   <= period_next;
      subPer_reg   <= subPer_next;
      subCnt_reg   <= subCnt_next;
      left_reg     <= left_next;
    end
  end

  // ************************************************************
  // Coil values and current scaling
  // ************************************************************
  sics_coil_t tableCoil;
  sics_coil_t coilSel;

  sics_sine_lut uSine (
    .angle (angle_reg),
    .coil  (tableCoil)
  );

  assign coilSel = direct_reg ? dcoil_reg : tableCoil;

  sics_current_scale uScale (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .currentScale (cs_reg),
    .reduceActive (pinLvl_reg[2] && standstill_flag_reg),
    .senseRange   (sense_range_select_reg),
    .coilIn       (coilSel),
    .coilTarget   (coilTarget),
    .thresholdMv  (senseThresholdMv)
  );

  assign busRdata         = rdata_reg;
  assign microstepAngle   = angle_reg;
  assign standstillFlag   = standstill_flag_reg;
  assign senseRangeSelect = sense_range_select_reg;

endmodule : sics_step_interpolator

// ### testbench/sics_step_monitor.sv
// Assertions on the step interpolator top-level ports.
// Bound into every instance of the top module; one clock domain.
`timescale 1ns/1ps
module sics_step_monitor #(
  parameter logic [19:0] INTERVAL_LIMIT = 20'hfffff
) (
  // Clock, reset and register port
  input wire logic               ref_clk,
  input wire logic               rst,
  input sics_pkg::sics_bus_req_t busReq,
  input wire logic [31:0]        busRdata,
  // Pins
  input wire logic               stepPin,
  input wire logic               dirPin,
  input wire logic               standaloneReducePin,
  // Block outputs
  input wire logic [9:0]         microstepAngle,
  input wire logic               standstillFlag,
  input sics_pkg::sics_target_t  coilTarget,
  input wire logic [8:0]         senseThresholdMv,
  input wire logic               senseRangeSelect
);
  import sics_pkg::*;
  logic [21:0] idleCnt_reg;
  logic [21:0] idleCnt_next;
  logic        stepPin_reg;
  // Cycles since the last rising step pin, saturating
  always_comb
    idleCnt_next = (stepPin && !stepPin_reg) ? 22'h0 :
      idleCnt_reg + {21'h0, ~&idleCnt_reg};
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      {idleCnt_reg, stepPin_reg} <= 23'h0;
    else
      {idleCnt_reg, stepPin_reg} <= {idleCnt_next, stepPin};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  rd_status_a: assert property (
    busReq.rd && busReq.addr == SICS_OFS_STATUS |=> busRdata ==
    {15'h0, $past(standstillFlag), 6'h0, $past(microstepAngle)})
    else $error("status read wrong");
  rd_period_a: assert property (
    busReq.rd && busReq.addr == SICS_OFS_PERIOD |=> busRdata[31:20] == 12'h0)
    else $error("period wider than 20 bits");
  range_low_a: assert property (
    senseRangeSelect [*2] |-> senseThresholdMv == SICS_VFS_LOW_MV)
    else $error("low range threshold wrong");
  range_high_a: assert property (
    (!senseRangeSelect) [*2] |-> senseThresholdMv == SICS_VFS_HIGH_MV)
    else $error("high range threshold wrong");
  target_max_a: assert property (
    coilTarget.a <= 10'sd325 && coilTarget.a >= -10'sd325 &&
    coilTarget.b <= 10'sd325 && coilTarget.b >= -10'sd325)
    else $error("target beyond full scale");
  still_late_a: assert property (
    $rose(standstillFlag) |-> idleCnt_reg >= {2'h0, INTERVAL_LIMIT})
    else $error("standstill too early");
  still_held_a: assert property (
    idleCnt_reg >= {2'h0, INTERVAL_LIMIT} + 22'h18 |-> standstillFlag)
    else $error("standstill missing");
  still_clear_a: assert property (
    standstillFlag && $rose(stepPin) |-> ##[1:8] !standstillFlag)
    else $error("standstill not cleared");
  count_up_a: assert property (
    (!dirPin) [*8] ##0 $changed(microstepAngle) |->
    10'(microstepAngle - $past(microstepAngle)) < 10'h200)
    else $error("angle moved down");
  count_down_a: assert property (
    dirPin [*8] ##0 $changed(microstepAngle) |->
    10'($past(microstepAngle) - microstepAngle) < 10'h200)
    else $error("angle moved up");
  cover property ($fell(standstillFlag));
  cover property (busReq.rd ##1 busRdata[16]);
  cover property (senseRangeSelect);
endmodule : sics_step_monitor

bind sics_step_interpolator sics_step_monitor #(
  .INTERVAL_LIMIT(INTERVAL_LIMIT)
) monitor (.ref_clk, .rst, .busReq, .busRdata, .stepPin, .dirPin,
  .standaloneReducePin, .microstepAngle, .standstillFlag, .coilTarget,
  .senseThresholdMv, .senseRangeSelect);

// ### testbench/sics_step_source.sv
// Step and direction controller model.
// Called by the bench right after a rising clock edge.
`timescale 1ns/1ps
module sics_step_source (
  // Clock and pins
  input  wire logic ref_clk,
  output logic      stepPin,
  output logic      dirPin
);
  initial {stepPin, dirPin} = 2'b00;
  // One step pulse of per cycles, half high and half low
  task automatic step(input logic d, input int per);
    @(posedge ref_clk);
    if (d !== dirPin)
    begin
      dirPin <= d;
      repeat (8) @(posedge ref_clk);
    end
    stepPin <= 1'b1;
    repeat (per / 2) @(posedge ref_clk);
    stepPin <= 1'b0;
    repeat (per - per / 2) @(posedge ref_clk);
  endtask : step
endmodule : sics_step_source

// ### testbench/tb.sv
// Self-checking bench of the step interpolator.
// Assumes package, design, step source and checker compiled first.
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module tb;
  import sics_pkg::*;
  localparam logic [19:0] LIMIT = 20'h00100;
  logic          ref_clk;
  logic          rst = 1'b1;
  logic          reducePin = 1'b0;
  sics_bus_req_t busReq = '0;
  logic [31:0]   busRdata;
  logic          stepPin;
  logic          dirPin;
  logic [9:0]    angle;
  logic          standstill;
  sics_target_t  target;
  logic [8:0]    thresholdMv;
  logic          rangeSel;
  int            n_mismatch = 0;
  int            n_checks = 0;
  sics_step_source src (.ref_clk, .stepPin, .dirPin);
  sics_step_interpolator #(.INTERVAL_LIMIT(LIMIT)) dut (.ref_clk, .rst,
    .busReq, .busRdata, .stepPin, .dirPin, .standaloneReducePin(reducePin),
    .microstepAngle(angle), .standstillFlag(standstill),
    .coilTarget(target), .senseThresholdMv(thresholdMv),
    .senseRangeSelect(rangeSel));
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge ref_clk);
    busReq <= '{addr, data, 1'b1, 1'b0};
    @(posedge ref_clk);
    busReq <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] addr, input logic [31:0] want);
    @(posedge ref_clk);
    busReq <= '{addr, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    busReq <= '0;
    #1 check(busRdata, want);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic reset_values();
    rd(SICS_OFS_DRV_CTRL, 32'h4);
    rd(SICS_OFS_LOAD_CUR, 32'h1f);
    wr(SICS_OFS_STATUS, 32'hffffffff);
    rd(SICS_OFS_STATUS, 32'h0);
    rd(8'h20, 32'h0);
  endtask : reset_values
  task automatic plain_steps();
    wr(SICS_OFS_DRV_CTRL, 32'h8);
    src.step(1'b0, 16);
    settle(0);
    `CHK(angle, 10'h100);
    wr(SICS_OFS_DRV_CTRL, 32'h4);
    src.step(1'b1, 16);
    settle(0);
    `CHK(angle, 10'h0f0);
    wr(SICS_OFS_DRV_CTRL, 32'h104);
    src.step(1'b0, 16);
    settle(0);
    `CHK(angle, 10'h110);
    wr(SICS_OFS_DRV_CTRL, 32'h4);
    src.step(1'b1, 16);
    settle(0);
    `CHK(angle, 10'h100);
  endtask : plain_steps
  task automatic current_scale();
    settle(2);
    `CHK({thresholdMv, target.a}, {9'h145, 10'h145});
    `CHK(target.b inside {10'h000, 10'h001, 10'h3ff}, 1'b1);
    wr(SICS_OFS_LOAD_CUR, 32'hf);
    settle(3);
    `CHK(target.a, 10'h0a2);
    wr(SICS_OFS_LOAD_CUR, 32'h0);
    settle(3);
    `CHK(target.a, 10'h00a);
    wr(SICS_OFS_LOAD_CUR, 32'h1f);
    wr(SICS_OFS_DRV_CONF, 32'h1);
    settle(3);
    `CHK({rangeSel, thresholdMv, target.a}, {1'b1, 9'h0ad, 10'h0ad});
    wr(SICS_OFS_DRV_CONF, 32'h2);
    wr(SICS_OFS_DIRECT, 32'h01ce0064);
    settle(3);
    `CHK(target, {10'h083, 10'h3bf});
    rd(SICS_OFS_DIRECT, 32'h01ce0064);
    wr(SICS_OFS_DRV_CONF, 32'h0);
  endtask : current_scale
  task automatic standstill_reduce();
    settle(LIMIT + 24);
    `CHK(standstill, 1'b1);
    rd(SICS_OFS_STATUS, 32'h00010100);
    wr(SICS_OFS_LOAD_CUR, 32'h7);
    settle(2);
    `CHK(target.a, 10'h051);
    wr(SICS_OFS_LOAD_CUR, 32'h1f);
    @(posedge ref_clk);
    reducePin <= 1'b1;
    settle(5);
    `CHK(target.a, 10'h0a2);
    src.step(1'b0, 16);
    reducePin <= 1'b0;
    settle(3);
    `CHK({standstill, target.a}, {1'b0, 10'h143});
  endtask : standstill_reduce
  task automatic interpolation();
    wr(SICS_OFS_DRV_CTRL, 32'h204);
    repeat (3) src.step(1'b0, 64);
    settle(8);
    `CHK(angle, 10'h140);
    rd(SICS_OFS_PERIOD, 32'h41);
    src.step(1'b0, 32);
    #1 `CHK(10'(angle - 10'h140) inside {[10'h001:10'h00f]}, 1'b1);
    src.step(1'b0, 32);
    settle(8);
    `CHK(angle, 10'h160);
  endtask : interpolation
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    reset_values();
    plain_steps();
    current_scale();
    standstill_reduce();
    interpolation();
    finish_test();
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end
endmodule : tb
